// *** acf_frontend_config.sv ***
// register bank for per-channel input span, bandwidth and oversampling setup
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R01] two four-bit span fields per byte register
// [R02] codes 0 to 4 are bipolar single-ended
// [R03] codes 5 to 7 are unipolar single-ended
// [R04] codes 8 to 11 are differential spans
// [R05] span registers reset to 0x33, read/write
// [R06] bandwidth bit n-1 enables channel n wideband
// [R07] bandwidth register resets zero, all bits RW
// [R08] padding lengthens the internal oversampling spacing
// [R09] ratio 0 off, 1..8 give 2..256
// [R10] oversampling register resets zero, fields RW
// [R11] external clock option paces conversions from pin
// [R12] host writes only listed range and ratio codes
module acf_frontend_config
	import acf_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire acf_bus_req_s reg_req,
	output logic [ACF_DW-1:0] reg_rdata,
	// per-channel front-end settings, channels 3 to 8
	output var acf_chan_cfg_s [ACF_NCH-1:0] chan_cfg,
	// bandwidth selection, channels 1 to 8
	output logic [ACF_NBW-1:0] wideband_en,
	// digital filter settings
	output var acf_avg_s avg_cfg,
	// conversion control
	input wire logic conversion_start_pin,
	output logic conv_trigger,
	output logic burst_done
);

	acf_top_s s_r;
	acf_top_s s_nxt;

	// per-channel decode of the held span codes
	logic [ACF_NCH-1:0][ACF_FLD_W-1:0] span_w;
	acf_span_e [ACF_NCH-1:0] cls_w;
	logic [ACF_NCH-1:0] rsvd_w;

	// sequencer status
	logic seq_busy;

	// write and read decode
	logic hit_cfg;
	logic hit_bw;
	logic hit_avg;
	logic hit_stat;
	logic [ACF_NPAIR-1:0] hit_range;
	logic [ACF_DW-1:0] cfg_view;
	logic [ACF_DW-1:0] avg_view;
	logic [ACF_DW-1:0] stat_view;

	assign hit_cfg = (reg_req.addr == ACF_OFS_CFG);
	assign hit_bw = (reg_req.addr == ACF_OFS_BW);
	assign hit_avg = (reg_req.addr == ACF_OFS_AVG);
	assign hit_stat = (reg_req.addr == ACF_OFS_STAT);
	assign hit_range[0] = (reg_req.addr == ACF_OFS_RANGE_B);
	assign hit_range[1] = (reg_req.addr == ACF_OFS_RANGE_C);
	assign hit_range[2] = (reg_req.addr == ACF_OFS_RANGE_D);

	genvar g;
	generate
		for (g = 0; g < ACF_NCH; g++)
		begin : g_chan
			// even index is the lower-numbered channel of the pair
			if (g % 2 == 0)
			begin : g_lo
				assign span_w[g] =
					s_r.range[g / 2][ACF_LO_LSB +: ACF_FLD_W]; // see [R01]
			end
			else
			begin : g_hi
				assign span_w[g] =
					s_r.range[g / 2][ACF_HI_LSB +: ACF_FLD_W]; // see [R01]
			end
			// see [R02] see [R03] see [R04]
			assign cls_w[g] = acf_classify(span_w[g]);
			// reserved codes are held as written and only flagged
			assign rsvd_w[g] = (cls_w[g] == ACF_SPAN_RSVD); // see [R12]
		end
	endgenerate

	// cfg holds only the external oversampling clock option
	always_comb
	begin
		cfg_view = ACF_RD_ZERO;
		cfg_view[ACF_EXTCLK_BIT] = s_r.avg.ext_clk;
	end

	always_comb
	begin
		avg_view = ACF_RD_ZERO;
		avg_view[ACF_HI_LSB +: ACF_FLD_W] = s_r.avg.pad;
		avg_view[ACF_LO_LSB +: ACF_FLD_W] = s_r.avg.ratio;
	end

	// status reports reserved codes in use and burst activity
	always_comb
	begin
		stat_view = ACF_RD_ZERO;
		stat_view[ACF_NCH-1:0] = s_r.span_rsvd;
		stat_view[ACF_STAT_RATIO_BIT] = s_r.ratio_rsvd;
		stat_view[ACF_STAT_BUSY_BIT] = seq_busy;
	end

	always_comb
	begin
		s_nxt = s_r;

		// write side; unmapped offsets and the status register ignore writes
		if (reg_req.wr)
		begin
			for (int i = 0; i < ACF_NPAIR; i++)
			begin
				if (hit_range[i])
					s_nxt.range[i] = reg_req.wdata; // see [R05]
			end
			if (hit_bw)
				s_nxt.bw = reg_req.wdata; // see [R07]
			if (hit_avg)
			begin
				s_nxt.avg.pad =
					reg_req.wdata[ACF_HI_LSB +: ACF_FLD_W]; // see [R10]
				s_nxt.avg.ratio =
					reg_req.wdata[ACF_LO_LSB +: ACF_FLD_W]; // see [R10]
			end
			if (hit_cfg)
				s_nxt.avg.ext_clk = reg_req.wdata[ACF_EXTCLK_BIT]; // see [R11]
		end

		// read side; data stands for exactly the cycle after the strobe
		s_nxt.rdata = ACF_RD_ZERO;
		if (reg_req.rd)
		begin
			if (hit_range[0])
				s_nxt.rdata = s_r.range[0]; // see [R05]
			else if (hit_range[1])
				s_nxt.rdata = s_r.range[1]; // see [R05]
			else if (hit_range[2])
				s_nxt.rdata = s_r.range[2]; // see [R05]
			else if (hit_bw)
				s_nxt.rdata = s_r.bw; // see [R07]
			else if (hit_avg)
				s_nxt.rdata = avg_view; // see [R10]
			else if (hit_cfg)
				s_nxt.rdata = cfg_view;
			else if (hit_stat)
				s_nxt.rdata = stat_view;
			else
				s_nxt.rdata = ACF_RD_ZERO;
		end

		// front-end outputs follow the held registers one cycle later
		for (int c = 0; c < ACF_NCH; c++)
		begin
			s_nxt.chan[c].span = span_w[c];
			s_nxt.chan[c].cls = cls_w[c];
		end
		s_nxt.span_rsvd = rsvd_w;
		s_nxt.ratio_rsvd = (s_r.avg.ratio > ACF_RATIO_MAX); // see [R12]
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			s_r.range <= {ACF_NPAIR{ACF_RST_RANGE}}; // see [R05]
			s_r.bw <= ACF_RST_BW; // see [R07]
			s_r.avg.pad <= ACF_RST_PAD; // see [R10]
			s_r.avg.ratio <= ACF_RST_RATIO; // see [R10]
			s_r.avg.ext_clk <= ACF_RST_EXTCLK;
			s_r.rdata <= ACF_RD_ZERO;
			for (int c = 0; c < ACF_NCH; c++)
			begin
				s_r.chan[c].span <= ACF_RST_RANGE[ACF_LO_LSB +: ACF_FLD_W];
				s_r.chan[c].cls <= ACF_SPAN_BIPOLAR;
			end
			s_r.span_rsvd <= '0;
			s_r.ratio_rsvd <= 1'b0;
		end
		else
			s_r <= s_nxt;
	end

	// burst pacing lives in its own module so its counters stay local
	acf_avg_seq u_seq (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.avg(s_r.avg),
		.conversion_start_pin(conversion_start_pin),
		.conv_trigger(conv_trigger),
		.burst_done(burst_done),
		.busy(seq_busy)
	);

	assign reg_rdata = s_r.rdata;
	assign chan_cfg = s_r.chan;
	assign wideband_en = s_r.bw; // see [R06]
	assign avg_cfg = s_r.avg;

endmodule // acf_frontend_config

`default_nettype wire

// *** acf_pkg.sv ***
// shared constants, types and helpers of the front-end configuration block
package acf_pkg;

	// register port geometry
	localparam int ACF_AW = 8;
	localparam int ACF_DW = 8;
	localparam int ACF_NCH = 6;
	localparam int ACF_NPAIR = 3;
	localparam int ACF_NBW = 8;
	localparam int ACF_FLD_W = 4;

	// register offsets
	localparam logic [ACF_AW-1:0] ACF_OFS_CFG = 8'h02;
	localparam logic [ACF_AW-1:0] ACF_OFS_RANGE_B = 8'h04;
	localparam logic [ACF_AW-1:0] ACF_OFS_RANGE_C = 8'h05;
	localparam logic [ACF_AW-1:0] ACF_OFS_RANGE_D = 8'h06;
	localparam logic [ACF_AW-1:0] ACF_OFS_BW = 8'h07;
	localparam logic [ACF_AW-1:0] ACF_OFS_AVG = 8'h08;
	localparam logic [ACF_AW-1:0] ACF_OFS_STAT = 8'h11;

	// reset values
	localparam logic [ACF_DW-1:0] ACF_RST_RANGE = 8'h33;
	localparam logic [ACF_DW-1:0] ACF_RST_BW = 8'h00;
	localparam logic [ACF_FLD_W-1:0] ACF_RST_PAD = 4'h0;
	localparam logic [ACF_FLD_W-1:0] ACF_RST_RATIO = 4'h0;
	localparam logic ACF_RST_EXTCLK = 1'h0;
	localparam logic [ACF_DW-1:0] ACF_RD_ZERO = 8'h00;

	// field positions
	localparam int ACF_HI_LSB = 4;
	localparam int ACF_LO_LSB = 0;
	localparam int ACF_EXTCLK_BIT = 5;
	localparam int ACF_STAT_RATIO_BIT = 6;
	localparam int ACF_STAT_BUSY_BIT = 7;

	// range and ratio code limits
	localparam logic [ACF_FLD_W-1:0] ACF_CODE_BIP_LAST = 4'h4;
	localparam logic [ACF_FLD_W-1:0] ACF_CODE_UNI_LAST = 4'h7;
	localparam logic [ACF_FLD_W-1:0] ACF_CODE_DIF_LAST = 4'hB;
	localparam logic [ACF_FLD_W-1:0] ACF_RATIO_OFF = 4'h0;
	localparam logic [ACF_FLD_W-1:0] ACF_RATIO_MAX = 4'h8;

	// oversampling timing
	localparam int ACF_CLK_PERIOD_PS = 5000;
	localparam int ACF_OS_BASE_NS = 1000;
	localparam int ACF_AVERAGING_PADDING_STEP_NS = 1000;
	localparam int ACF_OS_BASE_CYC =
		(ACF_OS_BASE_NS * 1000 + ACF_CLK_PERIOD_PS - 1) / ACF_CLK_PERIOD_PS;
	localparam int ACF_AVERAGING_PADDING_CYC =
		(ACF_AVERAGING_PADDING_STEP_NS * 1000 + ACF_CLK_PERIOD_PS - 1) / ACF_CLK_PERIOD_PS;
	localparam int ACF_GAP_W = 16;
	localparam int ACF_CNT_W = 9;

	typedef enum logic [1:0] {
		ACF_SPAN_BIPOLAR,
		ACF_SPAN_UNIPOLAR,
		ACF_SPAN_DIFF,
		ACF_SPAN_RSVD
	} acf_span_e;

	typedef enum logic [1:0] {
		ACF_SEQ_IDLE,
		ACF_SEQ_GAP,
		ACF_SEQ_EXT
	} acf_seq_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ACF_AW-1:0] addr;
		logic [ACF_DW-1:0] wdata;
	} acf_bus_req_s;

	typedef struct packed {
		logic [ACF_FLD_W-1:0] span;
		acf_span_e cls;
	} acf_chan_cfg_s;

	typedef struct packed {
		logic [ACF_FLD_W-1:0] pad;
		logic [ACF_FLD_W-1:0] ratio;
		logic ext_clk;
	} acf_avg_s;

	typedef struct packed {
		logic [ACF_NPAIR-1:0][ACF_DW-1:0] range;
		logic [ACF_NBW-1:0] bw;
		acf_avg_s avg;
		logic [ACF_DW-1:0] rdata;
		acf_chan_cfg_s [ACF_NCH-1:0] chan;
		logic [ACF_NCH-1:0] span_rsvd;
		logic ratio_rsvd;
	} acf_top_s;

	typedef struct packed {
		acf_seq_e st;
		logic [ACF_CNT_W-1:0] left;
		logic [ACF_GAP_W-1:0] gap;
		logic [ACF_GAP_W-1:0] gap_len;
		logic start_q;
		logic trig;
		logic done;
	} acf_seq_s;

	function automatic acf_span_e acf_classify(
		input logic [ACF_FLD_W-1:0] code
	);
		if (code <= ACF_CODE_BIP_LAST)
			return ACF_SPAN_BIPOLAR;
		else if (code <= ACF_CODE_UNI_LAST)
			return ACF_SPAN_UNIPOLAR;
		else if (code <= ACF_CODE_DIF_LAST)
			return ACF_SPAN_DIFF;
		else
			return ACF_SPAN_RSVD;
	endfunction

endpackage

// *** acf_avg_seq.sv ***
// oversampling burst sequencer driven by the conversion-start input
`timescale 1ns/1ps
`default_nettype none

module acf_avg_seq
	import acf_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// settings
	input wire acf_avg_s avg,
	// conversion control
	input wire logic conversion_start_pin,
	output logic conv_trigger,
	output logic burst_done,
	output logic busy
);

	acf_seq_s s_r;
	acf_seq_s s_nxt;
	logic start_edge;
	logic [ACF_FLD_W-1:0] ratio_eff;
	logic [ACF_CNT_W-1:0] burst_len;
	logic [ACF_GAP_W-1:0] gap_cyc;

	assign start_edge = conversion_start_pin & ~s_r.start_q;
	// reserved ratios fall back to single conversions
	assign ratio_eff = (avg.ratio > ACF_RATIO_MAX) ? ACF_RATIO_OFF : avg.ratio;
	assign burst_len = ACF_CNT_W'(1) << ratio_eff; // see [R09]
	// padding stretches the internal spacing in whole base steps
	assign gap_cyc = ACF_GAP_W'(ACF_OS_BASE_CYC)
		+ ACF_GAP_W'(avg.pad) * ACF_GAP_W'(ACF_AVERAGING_PADDING_CYC); // see [R08]

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.trig = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.start_q = conversion_start_pin;
		case (s_r.st)
			ACF_SEQ_IDLE:
			begin
				if (start_edge)
				begin
					s_nxt.trig = 1'b1;
					if (ratio_eff == ACF_RATIO_OFF)
						s_nxt.done = 1'b1;
					else
					begin
						s_nxt.left = burst_len - ACF_CNT_W'(1);
						s_nxt.gap_len = gap_cyc;
						s_nxt.gap = gap_cyc - ACF_GAP_W'(1);
						if (avg.ext_clk)
							s_nxt.st = ACF_SEQ_EXT; // see [R11]
						else
							s_nxt.st = ACF_SEQ_GAP;
					end
				end
			end
			ACF_SEQ_GAP:
			begin
				// start edges inside an internal burst are ignored
				if (s_r.gap == ACF_GAP_W'(0))
				begin
					s_nxt.trig = 1'b1;
					s_nxt.gap = s_r.gap_len - ACF_GAP_W'(1);
					s_nxt.left = s_r.left - ACF_CNT_W'(1);
					if (s_r.left == ACF_CNT_W'(1))
					begin
						s_nxt.done = 1'b1;
						s_nxt.st = ACF_SEQ_IDLE;
					end
				end
				else
					s_nxt.gap = s_r.gap - ACF_GAP_W'(1);
			end
			ACF_SEQ_EXT:
			begin
				if (start_edge)
				begin
					s_nxt.trig = 1'b1; // see [R11]
					s_nxt.left = s_r.left - ACF_CNT_W'(1);
					if (s_r.left == ACF_CNT_W'(1))
					begin
						s_nxt.done = 1'b1;
						s_nxt.st = ACF_SEQ_IDLE;
					end
				end
			end
			default:
				s_nxt.st = ACF_SEQ_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
			s_r.st <= ACF_SEQ_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	assign conv_trigger = s_r.trig;
	assign burst_done = s_r.done;
	assign busy = (s_r.st != ACF_SEQ_IDLE);

endmodule // acf_avg_seq

`default_nettype wire

// *** acf_frontend_config_chk.sv ***
// port assertions of the front-end configuration block
`timescale 1ns/1ps
`default_nettype none
module acf_frontend_config_chk
	import acf_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire acf_bus_req_s reg_req,
	input wire logic [ACF_DW-1:0] reg_rdata,
	// settings
	input wire acf_chan_cfg_s [ACF_NCH-1:0] chan_cfg,
	input wire logic [ACF_NBW-1:0] wideband_en,
	input wire acf_avg_s avg_cfg,
	// conversion
	input wire logic conversion_start_pin,
	input wire logic conv_trigger,
	input wire logic burst_done
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_rd_idle;
		!$past(reg_req.rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_rng;
		reg_req.wr && reg_req.addr == ACF_OFS_RANGE_B |-> ##2
		chan_cfg[1].span == $past(reg_req.wdata[7:4], 2) &&
		chan_cfg[0].span == $past(reg_req.wdata[3:0], 2);
	endproperty
	a_rng: assert property (p_rng)
		else $error("span fields misplaced");
	property p_bip;
		chan_cfg[0].span <= 4'h4 |-> chan_cfg[0].cls == ACF_SPAN_BIPOLAR;
	endproperty
	a_bip: assert property (p_bip)
		else $error("bipolar class wrong");
	property p_uni;
		chan_cfg[0].span inside {[4'h5:4'h7]} |->
		chan_cfg[0].cls == ACF_SPAN_UNIPOLAR;
	endproperty
	a_uni: assert property (p_uni)
		else $error("unipolar class wrong");
	property p_dif;
		chan_cfg[0].span inside {[4'h8:4'hB]} |->
		chan_cfg[0].cls == ACF_SPAN_DIFF;
	endproperty
	a_dif: assert property (p_dif)
		else $error("differential class wrong");
	property p_bw_wr;
		reg_req.wr && reg_req.addr == ACF_OFS_BW |=>
		wideband_en == $past(reg_req.wdata);
	endproperty
	a_bw_wr: assert property (p_bw_wr)
		else $error("bandwidth not written");
	property p_bw_hold;
		!(reg_req.wr && reg_req.addr == ACF_OFS_BW) |=> $stable(wideband_en);
	endproperty
	a_bw_hold: assert property (p_bw_hold)
		else $error("bandwidth changed alone");
	property p_avg_wr;
		reg_req.wr && reg_req.addr == ACF_OFS_AVG |=>
		{avg_cfg.pad, avg_cfg.ratio} == $past(reg_req.wdata);
	endproperty
	a_avg_wr: assert property (p_avg_wr)
		else $error("oversampling not written");
	property p_done;
		burst_done |-> conv_trigger;
	endproperty
	a_done: assert property (p_done)
		else $error("done without trigger");
	property p_gap;
		conv_trigger && !burst_done && !avg_cfg.ext_clk && avg_cfg.pad == 4'h0
		|-> ##200 conv_trigger;
	endproperty
	a_gap: assert property (p_gap)
		else $error("trigger spacing wrong");
	// cycles since the last trigger, and whether a burst is still open
	logic [15:0] since_trig;
	logic burst_open;
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || conv_trigger)
			since_trig <= 16'h0001;
		else if (since_trig != 16'hFFFF)
			since_trig <= since_trig + 16'h0001;
	end
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			burst_open <= 1'b0;
		else if (conv_trigger)
			burst_open <= !burst_done;
	end
	property p_pad;
		conv_trigger && burst_open && !avg_cfg.ext_clk |->
		since_trig == 16'(ACF_OS_BASE_CYC +
			int'(avg_cfg.pad) * ACF_AVERAGING_PADDING_CYC);
	endproperty
	a_pad: assert property (p_pad)
		else $error("padded trigger spacing wrong");
	property p_ext;
		conv_trigger && burst_open && avg_cfg.ext_clk |->
		$past(conversion_start_pin) && !$past(conversion_start_pin, 2);
	endproperty
	a_ext: assert property (p_ext)
		else $error("external trigger not paced by pin");
endmodule // acf_frontend_config_chk
bind acf_frontend_config acf_frontend_config_chk u_chk (.core_clk, .rst_n,
	.reg_req, .reg_rdata, .chan_cfg, .wideband_en, .avg_cfg,
	.conversion_start_pin, .conv_trigger, .burst_done);
`default_nettype wire

// *** acf_host_model.sv ***
// host model driving the register port and conversion start pin
`timescale 1ns/1ps
`default_nettype none
module acf_host_model
	import acf_pkg::*;
(
	// clock
	input wire logic core_clk,
	// register port and start pin
	output var acf_bus_req_s reg_req,
	output logic conversion_start_pin
);
	initial
	begin
		reg_req = '0;
		conversion_start_pin = 1'b0;
	end
	// released address and data show the inverse and both strobes drop, so stale values cannot pass
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{w, !w, a, d};
		@(posedge core_clk);
		reg_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic pulse;
		@(posedge core_clk);
		conversion_start_pin <= 1'b1;
		repeat (2) @(posedge core_clk);
		conversion_start_pin <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
endmodule // acf_host_model
`default_nettype wire

// *** acf_frontend_config_tb.sv ***
// self-checking bench of the front-end configuration block
`timescale 1ns/1ps
`default_nettype none
module acf_frontend_config_tb
	import acf_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	acf_bus_req_s reg_req;
	logic [ACF_DW-1:0] reg_rdata;
	acf_chan_cfg_s [ACF_NCH-1:0] chan_cfg;
	logic [ACF_NBW-1:0] wideband_en;
	acf_avg_s avg_cfg;
	logic conversion_start_pin;
	logic conv_trigger;
	logic burst_done;
	logic rd_q = 1'b0;
	logic [7:0] rd_exp[$];
	logic [7:0] dn;
	logic done_exp[$];
	logic [7:0] seed = 8'h36;
	int n_fail = 0;
	int cmp_count = 0;
	always #2.5 core_clk = ~core_clk;
	acf_host_model u_host (.core_clk, .reg_req, .conversion_start_pin);
	acf_frontend_config DUT (.core_clk, .rst_n, .reg_req, .reg_rdata,
		.chan_cfg, .wideband_en, .avg_cfg, .conversion_start_pin,
		.conv_trigger, .burst_done);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_exp.push_back(e);
		u_host.acc(1'b0, a, 8'h00);
	endtask
	task automatic burst(input logic [3:0] ratio, input logic [3:0] pad,
		input logic ext);
		int n;
		int k;
		n = (ratio == 4'h0) ? 1 : (1 << ratio);
		u_host.acc(1'b1, ACF_OFS_CFG, {2'h0, ext, 5'h00});
		u_host.acc(1'b1, ACF_OFS_AVG, {pad, ratio});
		for (int i = 1; i <= n; i++)
			done_exp.push_back(i == n);
		u_host.pulse();
		if (ext)
			repeat (n - 1) u_host.pulse();
		k = 0;
		while (done_exp.size() > 0 && k < 60000)
		begin
			@(posedge core_clk);
			k++;
		end
		if (k == 60000)
		begin
			n_fail++;
			report_and_stop();
		end
	endtask
	// results are compared in the order they were requested
	always @(posedge core_clk)
	begin
		if (rd_q)
			chk(reg_rdata, rd_exp.pop_front());
		if (conv_trigger === 1'b1)
		begin
			dn = 8'hEE;
			if (done_exp.size() > 0)
				dn = {7'h00, done_exp.pop_front()};
			chk({7'h00, burst_done}, dn);
		end
		rd_q <= reg_req.rd;
	end
	initial
	begin
		logic [7:0] d;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int r = 0; r < 3; r++)
			rd(8'(ACF_OFS_RANGE_B + r), 8'h33);
		rd(ACF_OFS_BW, 8'h00);
		rd(ACF_OFS_AVG, 8'h00);
		u_host.acc(1'b1, 8'h20, 8'hFF);
		rd(8'h20, 8'h00);
		for (int c = 0; c < 12; c++)
			for (int r = 0; r < 3; r++)
			begin
				d = {4'(11 - c), 4'(c)};
				u_host.acc(1'b1, 8'(ACF_OFS_RANGE_B + r), d);
				rd(8'(ACF_OFS_RANGE_B + r), d);
			end
		repeat (2) @(posedge core_clk);
		#1;
		for (int i = 0; i < 6; i++)
			chk({4'h0, chan_cfg[i].span}, i[0] ? 8'h00 : 8'h0B);
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			u_host.acc(1'b1, ACF_OFS_BW, seed);
			#1;
			chk(wideband_en, seed);
			rd(ACF_OFS_BW, seed);
		end
		rd(ACF_OFS_BW, seed);
		burst(4'h0, 4'h0, 1'b0);
		burst(4'h1, 4'h0, 1'b0);
		burst(4'h2, 4'h1, 1'b0);
		burst(4'h8, 4'h0, 1'b0);
		burst(4'h2, 4'h0, 1'b1);
		rd(ACF_OFS_AVG, 8'h02);
		rd(ACF_OFS_CFG, 8'h20);
		rd(ACF_OFS_STAT, 8'h00);
		repeat (4) @(posedge core_clk);
		report_and_stop();
	end
endmodule // acf_frontend_config_tb
`default_nettype wire
